// [design/lcd_cmd_pkg.sv]
// Purpose: shared constants, types and carriers of the LCD command decoder
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: no bus; configuration leaves the block as a packed struct
package lcd_cmd_pkg;
   localparam int COL_WIDTH = 8;
   localparam int PAGE_WIDTH = 4;
   localparam int LINE_WIDTH = 6;
   localparam int CONTRAST_WIDTH = 6;

   // reset values
   localparam logic [5:0] RST_CONTRAST = 6'h20;
   localparam logic [2:0] RST_REG_RATIO = 3'h4;
   localparam logic [2:0] RST_POWER = 3'h0;
   localparam logic [5:0] RST_START_LINE = 6'h00;
   localparam logic [7:0] RST_COLUMN = 8'h00;
   localparam logic [3:0] RST_PAGE = 4'h0;
   localparam logic [1:0] RST_TC = 2'h0;
   localparam logic [1:0] RST_INDICATOR = 2'h0;

   // address limits
   localparam logic [7:0] COL_LAST = 8'h83;

   // whole-byte commands
   localparam logic [7:0] CMD_CONTRAST = 8'h81;
   localparam logic [7:0] CMD_RMW_ENTER = 8'he0;
   localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
   localparam logic [7:0] CMD_NOP = 8'he3;
   localparam logic [7:0] CMD_RMW_EXIT = 8'hee;
   localparam logic [7:0] CMD_TEST_CLEAR = 8'hf0;

   // field positions inside command bytes
   localparam int SELECT_BIT = 0;
   localparam int COM_DIR_BIT = 3;
   localparam int POWER_BUFFER_BIT = 0;
   localparam int POWER_REG_BIT = 1;
   localparam int POWER_BOOST_BIT = 2;

   typedef enum logic [2:0] {
      bias_1_9, bias_1_7, bias_1_4, bias_1_5, bias_1_6, bias_1_8
   } bias_ratio_t;

   typedef enum logic [4:0] {
      op_col_low, op_col_high, op_reg_ratio, op_power, op_start_line, op_contrast,
      op_seg_remap, op_bias, op_entire_on, op_reverse, op_display_on, op_page,
      op_com_dir, op_rmw_enter, op_soft_reset, op_rmw_exit, op_indicator, op_nop,
      op_test_clear, op_test_set, op_unknown
   } opcode_t;

   typedef struct packed {
      logic [7:0] value;
      logic is_data;
   } host_byte_t;

   typedef struct packed {
      logic display_on;
      logic entire_on;
      logic reverse;
      logic seg_remap;
      logic com_reverse;
      logic rmw;
      logic mode_132x64_icon;
      logic [2:0] power;
      logic [2:0] reg_ratio;
      logic [5:0] contrast;
      logic [5:0] start_line;
      bias_ratio_t bias;
      logic [1:0] tc;
      logic [1:0] indicator;
      logic test_mode;
   } lcd_config_t;
endpackage : lcd_cmd_pkg

// [design/lcd_serial_shifter.sv]
// Purpose: assembles serial bits into bytes, msb first
// Assumes: serial clock and data already synchronous to sys_clk_i
// Notes: select line is taken on the eighth rising serial edge
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_shifter (
   // clock and clear
   input wire logic sys_clk_i,
   input wire logic clear_i,
   // serial pins
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic dc_i,
   // assembled byte
   output lcd_cmd_pkg::host_byte_t byte_o,
   output logic byte_valid_o
);
   logic sclk_prev;
   logic [6:0] shift;
   logic [2:0] count;
   logic rise;

   assign rise = sclk_i & ~sclk_prev;

   // prev starts high so a clock held high over reset gives no false edge
   always_ff @(posedge sys_clk_i) begin
      if (clear_i) begin
         sclk_prev <= 1'b1;
      end else begin
         sclk_prev <= sclk_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (clear_i) begin
         shift <= 7'h00;
         count <= 3'h0;
      end else if (rise) begin
         shift <= {shift[5:0], sdata_i};
         count <= count + 3'h1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (clear_i) begin
         byte_o <= '0;
         byte_valid_o <= 1'b0;
      end else begin
         byte_valid_o <= rise && (count == 3'h7);
         if (rise && (count == 3'h7)) begin
            byte_o <= '{value: {shift, sdata_i}, is_data: dc_i};
         end
      end
   end
endmodule : lcd_serial_shifter
`default_nettype wire

// [design/lcd_cmd_classifier.sv]
// Purpose: maps a command byte to its operation
// Assumes: byte is a command, select line low
// Notes: purely combinational; unlisted patterns give op_unknown
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_classifier (
   // command byte in
   input wire logic [7:0] cmd_i,
   // decoded operation
   output lcd_cmd_pkg::opcode_t op_o
);
   always_comb begin
      casez (cmd_i)
         8'b0000_????: op_o = lcd_cmd_pkg::op_col_low;
         8'b0001_????: op_o = lcd_cmd_pkg::op_col_high;
         8'b0010_0???: op_o = lcd_cmd_pkg::op_reg_ratio;
         8'b0010_1???: op_o = lcd_cmd_pkg::op_power;
         8'b01??_????: op_o = lcd_cmd_pkg::op_start_line;
         lcd_cmd_pkg::CMD_CONTRAST: op_o = lcd_cmd_pkg::op_contrast;
         8'b1010_000?: op_o = lcd_cmd_pkg::op_seg_remap;
         8'b1010_001?: op_o = lcd_cmd_pkg::op_bias;
         8'b1010_010?: op_o = lcd_cmd_pkg::op_entire_on;
         8'b1010_011?: op_o = lcd_cmd_pkg::op_reverse;
         8'b1010_110?: op_o = lcd_cmd_pkg::op_indicator;
         8'b1010_111?: op_o = lcd_cmd_pkg::op_display_on;
         8'b1011_????: op_o = lcd_cmd_pkg::op_page;
         8'b1100_????: op_o = lcd_cmd_pkg::op_com_dir;
         lcd_cmd_pkg::CMD_RMW_ENTER: op_o = lcd_cmd_pkg::op_rmw_enter;
         lcd_cmd_pkg::CMD_SOFT_RESET: op_o = lcd_cmd_pkg::op_soft_reset;
         lcd_cmd_pkg::CMD_NOP: op_o = lcd_cmd_pkg::op_nop;
         lcd_cmd_pkg::CMD_RMW_EXIT: op_o = lcd_cmd_pkg::op_rmw_exit;
         lcd_cmd_pkg::CMD_TEST_CLEAR: op_o = lcd_cmd_pkg::op_test_clear;
         8'b1111_????: op_o = lcd_cmd_pkg::op_test_set;
         default: op_o = lcd_cmd_pkg::op_unknown;
      endcase
   end
endmodule : lcd_cmd_classifier
`default_nettype wire

// [design/lcd_command_state_decoder.sv]
// Purpose: decodes host command bytes and holds the display configuration
// Assumes: all pins synchronous to sys_clk_i; one byte per cycle while par_wr_i is high
// Notes: data bytes are passed out as one-cycle memory writes
`timescale 1ns/1ps
`default_nettype none
module lcd_command_state_decoder (
   // clock and resets
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic chip_init_pin_n_i,
   // parallel host port
   input wire logic par_wr_i,
   input wire logic [7:0] par_data_i,
   input wire logic par_dc_i,
   // serial host port
   input wire logic serial_mode_i,
   input wire logic sclk_i,
   input wire logic sdata_i,
   // extended settings
   input wire logic ext_bias_wr_i,
   input wire lcd_cmd_pkg::bias_ratio_t ext_bias_i,
   input wire logic tc_wr_i,
   input wire logic [1:0] tc_i,
   // configuration and addresses
   output lcd_cmd_pkg::lcd_config_t cfg_o,
   output logic [7:0] column_o,
   output logic [3:0] page_o,
   // display memory write
   output logic mem_wr_o,
   output logic [7:0] mem_data_o,
   output logic [7:0] mem_col_o,
   output logic [3:0] mem_page_o
);
   typedef enum logic [1:0] {st_command, st_contrast_arg, st_indicator_arg} arg_state_t;

   arg_state_t state;
   lcd_cmd_pkg::host_byte_t ser_byte;
   lcd_cmd_pkg::host_byte_t in_byte;
   lcd_cmd_pkg::opcode_t op;
   lcd_cmd_pkg::bias_ratio_t bias;
   logic ser_valid;
   logic in_valid;
   logic cmd_valid;
   logic init;
   logic soft_reset;
   logic display_on;
   logic entire_on;
   logic reverse;
   logic seg_remap;
   logic com_reverse;
   logic rmw;
   logic mode_132x64_icon;
   logic test_mode;
   logic [2:0] power;
   logic [2:0] reg_ratio;
   logic [5:0] contrast;
   logic [5:0] start_line;
   logic [1:0] tc;
   logic [1:0] indicator;
   logic [7:0] column;
   logic [7:0] saved_column;
   logic [3:0] page;

   // every init source runs the same full initialisation
   assign init = reset_i || !chip_init_pin_n_i || soft_reset;

   lcd_serial_shifter u_shifter (
      .sys_clk_i(sys_clk_i),
      .clear_i(init || !serial_mode_i),
      .sclk_i(sclk_i),
      .sdata_i(sdata_i),
      .dc_i(par_dc_i),
      .byte_o(ser_byte),
      .byte_valid_o(ser_valid)
   );

   assign in_valid = serial_mode_i ? ser_valid : par_wr_i;
   assign in_byte = serial_mode_i ? ser_byte :
                    lcd_cmd_pkg::host_byte_t'{value: par_data_i, is_data: par_dc_i};
   assign cmd_valid = in_valid && !in_byte.is_data;

   lcd_cmd_classifier u_classifier (
      .cmd_i(in_byte.value),
      .op_o(op)
   );

   // software reset acts on the cycle after its byte
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || !chip_init_pin_n_i) begin
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= cmd_valid && (state == st_command) &&
                       (op == lcd_cmd_pkg::op_soft_reset);
      end
   end

   // argument bytes of two-byte commands
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         state <= st_command;
      end else if (cmd_valid) begin
         unique case (state)
            st_command: begin
               if (op == lcd_cmd_pkg::op_contrast) begin
                  state <= st_contrast_arg;
               end else if (op == lcd_cmd_pkg::op_indicator &&
                            in_byte.value[lcd_cmd_pkg::SELECT_BIT]) begin
                  state <= st_indicator_arg;
               end
            end
            st_contrast_arg: state <= st_command;
            st_indicator_arg: state <= st_command;
         endcase
      end
   end

   // display switches and mapping
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         display_on <= 1'b0;
         entire_on <= 1'b0;
         reverse <= 1'b0;
         seg_remap <= 1'b0;
         com_reverse <= 1'b0;
         mode_132x64_icon <= 1'b1;
      end else if (cmd_valid && state == st_command) begin
         unique case (op)
            lcd_cmd_pkg::op_display_on: display_on <= in_byte.value[lcd_cmd_pkg::SELECT_BIT];
            lcd_cmd_pkg::op_entire_on: entire_on <= in_byte.value[lcd_cmd_pkg::SELECT_BIT];
            lcd_cmd_pkg::op_reverse: reverse <= in_byte.value[lcd_cmd_pkg::SELECT_BIT];
            lcd_cmd_pkg::op_seg_remap: seg_remap <= in_byte.value[lcd_cmd_pkg::SELECT_BIT];
            lcd_cmd_pkg::op_com_dir: com_reverse <= in_byte.value[lcd_cmd_pkg::COM_DIR_BIT];
            default: ;
         endcase
      end
   end

   // voltage generator settings
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         power <= lcd_cmd_pkg::RST_POWER;
         reg_ratio <= lcd_cmd_pkg::RST_REG_RATIO;
         contrast <= lcd_cmd_pkg::RST_CONTRAST;
      end else if (cmd_valid && state == st_contrast_arg) begin
         contrast <= in_byte.value[5:0];
      end else if (cmd_valid && state == st_command) begin
         if (op == lcd_cmd_pkg::op_power) begin
            power <= in_byte.value[2:0];
         end
         if (op == lcd_cmd_pkg::op_reg_ratio) begin
            reg_ratio <= in_byte.value[2:0];
         end
      end
   end

   // bias ratio: two choices by command, the rest by the extension port
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         bias <= lcd_cmd_pkg::bias_1_9;
      end else if (cmd_valid && state == st_command && op == lcd_cmd_pkg::op_bias) begin
         bias <= in_byte.value[lcd_cmd_pkg::SELECT_BIT] ? lcd_cmd_pkg::bias_1_7
                                                        : lcd_cmd_pkg::bias_1_9;
      end else if (ext_bias_wr_i) begin
         bias <= ext_bias_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         tc <= lcd_cmd_pkg::RST_TC;
      end else if (tc_wr_i) begin
         tc <= tc_i;
      end
   end

   // indicator and test mode
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         indicator <= lcd_cmd_pkg::RST_INDICATOR;
         test_mode <= 1'b0;
      end else if (cmd_valid && state == st_indicator_arg) begin
         indicator <= in_byte.value[1:0];
      end else if (cmd_valid && state == st_command) begin
         if (op == lcd_cmd_pkg::op_indicator && !in_byte.value[lcd_cmd_pkg::SELECT_BIT]) begin
            indicator <= lcd_cmd_pkg::RST_INDICATOR;
         end
         if (op == lcd_cmd_pkg::op_test_set) begin
            test_mode <= 1'b1;
         end
         if (op == lcd_cmd_pkg::op_test_clear) begin
            test_mode <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         start_line <= lcd_cmd_pkg::RST_START_LINE;
      end else if (cmd_valid && state == st_command && op == lcd_cmd_pkg::op_start_line) begin
         start_line <= in_byte.value[5:0];
      end
   end

   // column, page and read-modify-write; data writes advance the column except at COL_LAST
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         column <= lcd_cmd_pkg::RST_COLUMN;
         saved_column <= lcd_cmd_pkg::RST_COLUMN;
         page <= lcd_cmd_pkg::RST_PAGE;
         rmw <= 1'b0;
      end else if (in_valid && in_byte.is_data) begin
         if (column != lcd_cmd_pkg::COL_LAST) begin
            column <= column + 8'h01;
         end
      end else if (cmd_valid && state == st_command) begin
         unique case (op)
            lcd_cmd_pkg::op_col_low: column[3:0] <= in_byte.value[3:0];
            lcd_cmd_pkg::op_col_high: column[7:4] <= in_byte.value[3:0];
            lcd_cmd_pkg::op_page: page <= in_byte.value[3:0];
            lcd_cmd_pkg::op_rmw_enter: begin
               rmw <= 1'b1;
               saved_column <= column;
            end
            lcd_cmd_pkg::op_rmw_exit: begin
               rmw <= 1'b0;
               column <= saved_column;
            end
            default: ;
         endcase
      end
   end

   // display memory write port
   always_ff @(posedge sys_clk_i) begin
      if (init) begin
         mem_wr_o <= 1'b0;
         mem_data_o <= 8'h00;
         mem_col_o <= 8'h00;
         mem_page_o <= 4'h0;
      end else begin
         mem_wr_o <= in_valid && in_byte.is_data;
         if (in_valid && in_byte.is_data) begin
            mem_data_o <= in_byte.value;
            mem_col_o <= column;
            mem_page_o <= page;
         end
      end
   end

   assign column_o = column;
   assign page_o = page;
   assign cfg_o = '{display_on: display_on, entire_on: entire_on, reverse: reverse,
                    seg_remap: seg_remap, com_reverse: com_reverse, rmw: rmw,
                    mode_132x64_icon: mode_132x64_icon, power: power,
                    reg_ratio: reg_ratio, contrast: contrast, start_line: start_line,
                    bias: bias, tc: tc, indicator: indicator, test_mode: test_mode};

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   pin_init_state_a: assert property (!chip_init_pin_n_i |=> !cfg_o.display_on &&
      cfg_o.contrast == 6'h20 && cfg_o.power == 3'h0 && column_o == 8'h00)
      else $error("init pin did not load reset state");
   // soft reset loads the same state one cycle after its byte
   soft_init_a: assert property (soft_reset |=> !cfg_o.display_on &&
      cfg_o.contrast == 6'h20 && cfg_o.power == 3'h0 && column_o == 8'h00)
      else $error("soft reset did not load reset state");
   reset_release_a: assert property ($fell(reset_i) |-> !cfg_o.display_on && !cfg_o.rmw &&
      !cfg_o.seg_remap && !cfg_o.com_reverse && cfg_o.mode_132x64_icon && !cfg_o.test_mode)
      else $error("switches wrong after reset");
   reset_values_a: assert property ($fell(reset_i) |-> cfg_o.bias == lcd_cmd_pkg::bias_1_9 &&
      cfg_o.indicator == 2'h0 && cfg_o.reg_ratio == 3'h4 && page_o == 4'h0 && cfg_o.tc == 2'h0)
      else $error("settings wrong after reset");

   // one-byte commands load on the next edge
   col_low_load_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_col_low |=> column_o[3:0] == $past(in_byte.value[3:0]))
      else $error("column low nibble not loaded");
   col_high_load_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_col_high |=> column_o[7:4] == $past(in_byte.value[3:0]))
      else $error("column high nibble not loaded");
   ratio_load_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_reg_ratio |=> cfg_o.reg_ratio == $past(in_byte.value[2:0]))
      else $error("ratio not loaded");
   power_load_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_power |=> cfg_o.power == $past(in_byte.value[2:0]))
      else $error("power bits not loaded");
   start_line_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_start_line |=> cfg_o.start_line == $past(in_byte.value[5:0]))
      else $error("start line not loaded");
   remap_load_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_seg_remap |=> cfg_o.seg_remap == $past(in_byte.value[0]))
      else $error("segment map not set");

   // mode switches and settings
   com_dir_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_com_dir |=> cfg_o.com_reverse == $past(in_byte.value[3]))
      else $error("scan direction not set");
   display_on_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_display_on |=> cfg_o.display_on == $past(in_byte.value[0]))
      else $error("display switch not set");
   rmw_enter_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_rmw_enter |=> cfg_o.rmw)
      else $error("rmw not entered");
   bias_cmd_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_bias |=> cfg_o.bias == ($past(in_byte.value[0]) ?
      lcd_cmd_pkg::bias_1_7 : lcd_cmd_pkg::bias_1_9)) else $error("bias not set");
   ext_bias_a: assert property (ext_bias_wr_i && !init &&
      !(cmd_valid && state == st_command && op == lcd_cmd_pkg::op_bias)
      |=> cfg_o.bias == $past(ext_bias_i)) else $error("extended bias not loaded");
   tc_load_a: assert property (tc_wr_i && !init
      |=> cfg_o.tc == $past(tc_i))
      else $error("temperature coefficient not loaded");

   // the two-byte contrast command enters its argument state and leaves it after the argument byte
   contrast_arm_a: assert property (cmd_valid && !init && state == st_command &&
      op == lcd_cmd_pkg::op_contrast |=> state == st_contrast_arg)
      else $error("contrast argument not awaited");
   contrast_pair_a: assert property (cmd_valid && !init && state == st_contrast_arg
      |=> cfg_o.contrast == $past(in_byte.value[5:0]) && state == st_command)
      else $error("contrast argument not taken");

   // display data goes to memory at the counters
   data_write_a: assert property (in_valid && in_byte.is_data && !init
      |=> mem_wr_o && mem_data_o == $past(in_byte.value) && $stable(cfg_o))
      else $error("data byte not routed to memory");
   mem_addr_a: assert property (in_valid && in_byte.is_data && !init
      |=> mem_col_o == $past(column_o) && mem_page_o == $past(page_o))
      else $error("memory address wrong");
   column_step_a: assert property (in_valid && in_byte.is_data && !init &&
      column_o != lcd_cmd_pkg::COL_LAST |=> column_o == $past(column_o) + 8'h01)
      else $error("column did not advance");
   cmd_no_write_a: assert property (cmd_valid && !init
      |=> !mem_wr_o)
      else $error("command written to memory");

   // main scenarios
   contrast_cmd_c: cover property (state == st_contrast_arg ##[1:20] state == st_command);
   serial_byte_c: cover property (serial_mode_i && ser_valid && !ser_byte.is_data);
   rmw_cycle_c: cover property (rmw ##[1:50] !rmw);
   soft_init_c: cover property (soft_reset ##1 !cfg_o.display_on);
   rmw_write_c: cover property (mem_wr_o && cfg_o.rmw);
endmodule : lcd_command_state_decoder
`default_nettype wire

// [verification/lcd_host_model.sv]
// Purpose: host side of the decoder: parallel strobes and serial frames
// Assumes: pins change at the falling edge of sys_clk_i
// Notes: released lines show the inverse of the last value driven
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
   // clock
   input wire logic sys_clk_i,
   // parallel and shared pins
   output logic par_wr_o,
   output logic [7:0] par_data_o,
   output logic par_dc_o,
   // serial pins
   output logic serial_mode_o,
   output logic sclk_o,
   output logic sdata_o
);
   initial begin
      par_wr_o = 1'b0;
      par_data_o = 8'h00;
      par_dc_o = 1'b0;
      serial_mode_o = 1'b0;
      sclk_o = 1'b0;
      sdata_o = 1'b0;
   end

   task automatic set_serial(input logic on);
      @(negedge sys_clk_i);
      serial_mode_o = on;
   endtask : set_serial

   // strobe held high for n bytes in a row, one byte per cycle
   task automatic put_par(input logic [15:0] value, input logic dc, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge sys_clk_i);
         par_wr_o = 1'b1;
         par_data_o = value[i*8 +: 8];
         par_dc_o = dc;
      end
      @(negedge sys_clk_i);
      par_wr_o = 1'b0;
      par_data_o = ~par_data_o;
      par_dc_o = ~dc;
   endtask : put_par

   // msb first on rising clock; clock stands low between frames
   task automatic put_ser(input logic [7:0] value, input logic dc, input int nbits);
      for (int i = 7; i > 7 - nbits; i--) begin
         @(negedge sys_clk_i);
         sclk_o = 1'b0;
         sdata_o = value[i];
         par_dc_o = dc;
         @(negedge sys_clk_i);
         sclk_o = 1'b1;
      end
      @(negedge sys_clk_i);
      sclk_o = 1'b0;
      sdata_o = ~sdata_o;
      par_dc_o = ~dc;
   endtask : put_ser
endmodule : lcd_host_model
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench of the command decoder
// Assumes: 20 MHz clock, inputs driven at the falling edge
// Notes: every scenario task drives and judges its own traffic
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin errors++; $display("wrong value at %0t ns: %s", $time, msg); end end
module tb;
   logic sys_clk_i, reset_i, init_n, ebias_wr, tc_wr, wr, dc, smode, sclk, sdata;
   logic [7:0] pdata, column, mem_data, mem_col;
   logic [1:0] tc;
   logic [3:0] page, mem_page;
   logic mem_wr;
   lcd_cmd_pkg::bias_ratio_t ebias;
   lcd_cmd_pkg::lcd_config_t cfg;
   int errors = 0;
   int check_count = 0;

   lcd_host_model lcd_host_model_i (.sys_clk_i(sys_clk_i), .par_wr_o(wr), .par_data_o(pdata),
      .par_dc_o(dc), .serial_mode_o(smode), .sclk_o(sclk), .sdata_o(sdata));
   lcd_command_state_decoder lcd_command_state_decoder_i (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .chip_init_pin_n_i(init_n), .par_wr_i(wr), .par_data_i(pdata),
      .par_dc_i(dc), .serial_mode_i(smode), .sclk_i(sclk), .sdata_i(sdata),
      .ext_bias_wr_i(ebias_wr), .ext_bias_i(ebias), .tc_wr_i(tc_wr), .tc_i(tc),
      .cfg_o(cfg), .column_o(column), .page_o(page), .mem_wr_o(mem_wr),
      .mem_data_o(mem_data), .mem_col_o(mem_col), .mem_page_o(mem_page));

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic final_report;
      if (errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic cmd(input logic [7:0] value);
      lcd_host_model_i.put_par({8'h00, value}, 1'b0, 1);
      repeat (2) @(negedge sys_clk_i);
   endtask : cmd

   task automatic wait_mem;
      int n;
      n = 0;
      while (mem_wr !== 1'b1 && n < 5) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (mem_wr !== 1'b1) begin
         errors++;
         $display("wrong value at %0t ns: no memory write", $time);
         final_report();
      end
   endtask : wait_mem

   task automatic pulse_init;
      @(negedge sys_clk_i);
      init_n = 1'b0;
      @(negedge sys_clk_i);
      init_n = 1'b1;
      @(negedge sys_clk_i);
   endtask : pulse_init

   task automatic check_defaults;
      `CHECK(cfg.display_on, 1'b0, "display enable");
      `CHECK(cfg.mode_132x64_icon, 1'b1, "display mode");
      `CHECK(cfg.seg_remap, 1'b0, "segment map");
      `CHECK(cfg.rmw, 1'b0, "rmw flag");
      `CHECK(cfg.power, 3'h0, "power bits");
      `CHECK(cfg.bias, lcd_cmd_pkg::bias_1_9, "bias");
      `CHECK(cfg.indicator, 2'h0, "indicator");
      `CHECK(column, 8'h00, "column");
      `CHECK(page, 4'h0, "page");
      `CHECK(cfg.com_reverse, 1'b0, "scan direction");
      `CHECK(cfg.contrast, 6'h20, "contrast");
      `CHECK(cfg.test_mode, 1'b0, "test mode");
      `CHECK(cfg.reg_ratio, 3'h4, "ratio");
      `CHECK(cfg.start_line, 6'h00, "start line");
      `CHECK(cfg.tc, 2'h0, "temp coefficient");
   endtask : check_defaults

   task automatic t_column;
      cmd(8'h18);
      cmd(8'h03);
      `CHECK(column, 8'h83, "column nibbles");
      cmd(8'hb5);
      lcd_host_model_i.put_par(16'h005a, 1'b1, 1);
      wait_mem();
      `CHECK(mem_data, 8'h5a, "memory data");
      `CHECK(mem_col, 8'h83, "memory column");
      `CHECK(mem_page, 4'h5, "memory page");
      @(negedge sys_clk_i);
      `CHECK(mem_wr, 1'b0, "write pulse length");
      cmd(8'h02);
      `CHECK(column, 8'h82, "low nibble only");
      cmd(8'he0);
      `CHECK(cfg.rmw, 1'b1, "rmw entered");
      lcd_host_model_i.put_par(16'h0011, 1'b1, 1);
      wait_mem();
      `CHECK(column, 8'h83, "column step");
      cmd(8'hee);
      `CHECK(column, 8'h82, "column restored");
      `CHECK(cfg.rmw, 1'b0, "rmw left");
   endtask : t_column

   task automatic t_settings;
      logic [2:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 3'(i);
         cmd({5'b00100, v});
         `CHECK(cfg.reg_ratio, v, "ratio");
      end
      for (int i = 0; i < 3; i++) begin
         v = 3'h1 << i;
         cmd({5'b00101, v});
         `CHECK(cfg.power, v, "power bits");
      end
      cmd(8'h7f);
      `CHECK(cfg.start_line, 6'h3f, "start line");
      cmd(8'ha1);
      `CHECK(cfg.seg_remap, 1'b1, "segment remap");
      cmd(8'ha0);
      `CHECK(cfg.seg_remap, 1'b0, "segment normal");
      cmd(8'ha3);
      `CHECK(cfg.bias, lcd_cmd_pkg::bias_1_7, "bias 1/7");
      cmd(8'hc8);
      `CHECK(cfg.com_reverse, 1'b1, "scan reversed");
      for (int i = 5; i >= 0; i--) begin
         ebias = lcd_cmd_pkg::bias_ratio_t'(3'(i));
         ebias_wr = 1'b1;
         tc = 2'(i);
         tc_wr = 1'b1;
         @(negedge sys_clk_i);
         ebias_wr = 1'b0;
         tc_wr = 1'b0;
         @(negedge sys_clk_i);
         `CHECK(cfg.bias, lcd_cmd_pkg::bias_ratio_t'(3'(i)), "extended bias");
         `CHECK(cfg.tc, 2'(i), "temp coefficient");
      end
   endtask : t_settings

   task automatic t_contrast;
      lcd_host_model_i.put_par(16'h81ff, 1'b0, 2);
      repeat (2) @(negedge sys_clk_i);
      `CHECK(cfg.contrast, 6'h3f, "contrast value");
      `CHECK(cfg.test_mode, 1'b0, "argument taken as command");
      cmd(8'h40);
      `CHECK(cfg.start_line, 6'h00, "command after argument");
      `CHECK(cfg.contrast, 6'h3f, "contrast held");
   endtask : t_contrast

   task automatic t_serial;
      lcd_host_model_i.set_serial(1'b1);
      lcd_host_model_i.put_ser(8'h2f, 1'b0, 8);
      repeat (3) @(negedge sys_clk_i);
      `CHECK(cfg.power, 3'h7, "serial command");
      lcd_host_model_i.put_ser(8'ha5, 1'b1, 8);
      wait_mem();
      `CHECK(mem_data, 8'ha5, "serial data");
      lcd_host_model_i.put_ser(8'hff, 1'b0, 3);
      pulse_init();
      check_defaults();
      lcd_host_model_i.put_ser(8'h25, 1'b0, 8);
      repeat (3) @(negedge sys_clk_i);
      `CHECK(cfg.reg_ratio, 3'h5, "partial bits dropped");
      lcd_host_model_i.set_serial(1'b0);
   endtask : t_serial

   task automatic t_init;
      cmd(8'haf);
      cmd(8'h81);
      cmd(8'h11);
      `CHECK(cfg.display_on, 1'b1, "display on");
      pulse_init();
      check_defaults();
      cmd(8'haf);
      cmd(8'h14);
      `CHECK(column, 8'h40, "column before soft init");
      cmd(8'he2);
      @(negedge sys_clk_i);
      check_defaults();
   endtask : t_init

   initial begin
      reset_i = 1'b1;
      init_n = 1'b1;
      ebias_wr = 1'b0;
      ebias = lcd_cmd_pkg::bias_1_9;
      tc_wr = 1'b0;
      tc = 2'h0;
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      reset_i = 1'b0;
      @(negedge sys_clk_i);
      check_defaults();
      t_column();
      t_settings();
      t_contrast();
      t_serial();
      t_init();
      final_report();
   end
endmodule : tb
`default_nettype wire
